//--- inc/ovp_pkg.sv
// constants and types shared by the input overvoltage fault handler
package ovp_pkg;
    // register command codes
    localparam logic [7:0] THRESHOLD_ADDR = 8'h55;
    localparam logic [7:0] ACTION_ADDR = 8'h56;

    // threshold register layout
    localparam int THR_EXP_MSB = 15;
    localparam int THR_EXP_LSB = 11;
    localparam int THR_HI_MSB = 10;
    localparam int THR_HI_LSB = 8;
    localparam int THR_LO_MSB = 7;
    localparam int THR_LO_LSB = 0;
    localparam int MANT_W = 11;
    localparam int EXP_W = 3;
    localparam int VOLT_W = MANT_W + (1 << EXP_W) - 1;

    // action register layout
    localparam int ACT_RESP_MSB = 7;
    localparam int ACT_RESP_LSB = 6;
    localparam int ACT_RETRY_MSB = 5;
    localparam int ACT_RETRY_LSB = 3;
    localparam int ACT_DELAY_MSB = 2;
    localparam int ACT_DELAY_LSB = 0;

    // reset values
    localparam logic [10:0] THR_MANT_RESET = 11'h7ff;
    localparam logic [7:0] ACTION_RESET = 8'h00;

    localparam logic [2:0] RETRY_INFINITE = 3'h7;

    // timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int MS_IN_NS = 1000000;
    localparam int CYCLES_PER_MS = MS_IN_NS / CLK_PERIOD_NS;
    localparam int MS_W = 12;

    typedef logic [MS_W-1:0] ms_t;
    typedef ms_t delay_table_t [8];

    // first delay in ms, doubling per code
    localparam delay_table_t DELAY1_MS = '{12'd10, 12'd20, 12'd40, 12'd80,
                                           12'd160, 12'd320, 12'd640, 12'd1280};
    // second delay in ms, spacing of retry attempts
    localparam delay_table_t DELAY2_MS = '{12'd252, 12'd558, 12'd924, 12'd1260,
                                           12'd1596, 12'd1932, 12'd2268, 12'd2604};

    typedef enum logic [1:0]
    {
        RESP_IGNORE = 2'h0,
        RESP_RIDE = 2'h1,
        RESP_RETRY = 2'h2,
        RESP_HOLD = 2'h3
    } resp_t;

    // gray steps along run -> ride -> off -> retry
    typedef enum logic [2:0]
    {
        ST_RUN = 3'h0,
        ST_RIDE = 3'h1,
        ST_OFF = 3'h3,
        ST_TRY = 3'h2,
        ST_HOLD = 3'h6,
        ST_LATCH = 3'h7
    } state_t;
endpackage

//--- inc/ms_timer_if.sv
// control and status between the fault state machine and its millisecond timer
`timescale 1ns/1ps
interface ms_timer_if;
    logic start;
    logic [ovp_pkg::MS_W-1:0] load_ms;
    logic done;

    modport ctrl (output start, output load_ms, input done);
    modport timer (input start, input load_ms, output done);
endinterface

//--- src/ms_timer.sv
// millisecond tick divider and down counter for the fault delays
`timescale 1ns/1ps
module ms_timer
#(
    parameter int CYCLES_PER_MS = ovp_pkg::CYCLES_PER_MS
)
(
    input wire logic clk,
    input wire logic rst,
    ms_timer_if.timer tif
);
    logic [15:0] div_ff;
    logic [15:0] nxt_div;
    logic [ovp_pkg::MS_W-1:0] ms_ff;
    logic [ovp_pkg::MS_W-1:0] nxt_ms;
    logic done_ff;
    logic nxt_done;
    logic tick;

    // start restarts the divider too, so the first ms is a full one
    always_comb
    begin
        tick = (div_ff == 16'(CYCLES_PER_MS - 1));
        nxt_div = tick ? 16'h0000 : div_ff + 16'h0001;
        nxt_ms = ms_ff;
        nxt_done = done_ff;
        if (tif.start)
        begin
            nxt_div = 16'h0000;
            nxt_ms = tif.load_ms;
            nxt_done = 1'b0;
        end
        else if (tick && !done_ff)
        begin
            if (ms_ff <= 12'h001)
                nxt_done = 1'b1;
            else
                nxt_ms = ms_ff - 12'h001;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            div_ff <= 16'h0000;
            ms_ff <= 12'h000;
            done_ff <= 1'b1;
        end
        else
        begin
            div_ff <= nxt_div;
            ms_ff <= nxt_ms;
            done_ff <= nxt_done;
        end
    end

    assign tif.done = done_ff;
endmodule // ms_timer

//--- src/input_overvoltage_fault_handler.sv
// input overvoltage threshold compare, register pair and fault response sequencer
`timescale 1ns/1ps
// How it works
// [R1] fault flagged while measured input voltage is above the programmed threshold
// [R2] threshold is an 11-bit mantissa, high 3 and low 8 bits, times 2^N
// [R3] threshold bits 15:11 read back the exponent N, writes there ignored
// [R4] response code 00 leaves the output on through the fault, though FAULT_ACTIVE still flags it
// [R5] code 01 rides through the first delay, then retries if fault remains
// [R6] code 10 shuts down at once and retries spaced by the second delay
// [R7] code 11 holds the output off until the fault clears, then re-enables
// [R8] the action register governs only this overvoltage channel
// [R9] retry field gives zero to six retries, code 111 retries forever
// [R10] retries exhausted with fault present keep output off until reset
// [R11] ms timer restarts on each new fault under codes 01 and 10 and on each retry attempt
module input_overvoltage_fault_handler
#(
    parameter int CYCLES_PER_MS = ovp_pkg::CYCLES_PER_MS
)
(
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire logic [7:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [15:0] REG_RDATA,
    output logic REG_RVALID,
    input wire logic [ovp_pkg::EXP_W-1:0] EXPONENT_N,
    input wire logic [ovp_pkg::VOLT_W-1:0] INPUT_LINE_VOLTAGE,
    output logic OUTPUT_ENABLE,
    output logic FAULT_ACTIVE,
    output logic LATCHED_OFF
);
    logic [ovp_pkg::MANT_W-1:0] mant_ff;
    logic [ovp_pkg::MANT_W-1:0] nxt_mant;
    logic [7:0] action_ff;
    logic [7:0] nxt_action;
    logic [15:0] rdata_ff;
    logic [15:0] nxt_rdata;
    logic rvalid_ff;
    logic nxt_rvalid;

    logic fault_ff;
    logic nxt_fault;
    logic [ovp_pkg::VOLT_W-1:0] limit;

    ovp_pkg::state_t state_ff;
    ovp_pkg::state_t nxt_state;
    logic [2:0] retries_ff;
    logic [2:0] nxt_retries;
    logic enable_ff;
    logic nxt_enable;

    ovp_pkg::resp_t resp;
    logic [2:0] retry_cfg;
    logic [2:0] delay_code;
    logic retry_left;

    ms_timer_if tif ();

    ms_timer #(
        .CYCLES_PER_MS(CYCLES_PER_MS)
    ) u_timer (
        .clk(CLK_SYS),
        .rst(RESET),
        .tif(tif)
    );

    // register file
    always_comb
    begin
        nxt_mant = mant_ff;
        nxt_action = action_ff;
        nxt_rdata = rdata_ff;
        nxt_rvalid = REG_RD;
        if (REG_WR)
        begin
            if (REG_ADDR == ovp_pkg::THRESHOLD_ADDR)
                nxt_mant = REG_WDATA[ovp_pkg::THR_HI_MSB:ovp_pkg::THR_LO_LSB]; // [R2] [R3]
            else if (REG_ADDR == ovp_pkg::ACTION_ADDR)
                nxt_action = REG_WDATA[7:0];
        end
        if (REG_RD)
        begin
            case (REG_ADDR)
                ovp_pkg::THRESHOLD_ADDR:
                    nxt_rdata = {2'h0, EXPONENT_N, mant_ff}; // [R3]
                ovp_pkg::ACTION_ADDR:
                    nxt_rdata = {8'h00, action_ff};
                default:
                    nxt_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (RESET)
        begin
            mant_ff <= ovp_pkg::THR_MANT_RESET;
            action_ff <= ovp_pkg::ACTION_RESET;
            rdata_ff <= 16'h0000;
            rvalid_ff <= 1'b0;
        end
        else
        begin
            mant_ff <= nxt_mant;
            action_ff <= nxt_action;
            rdata_ff <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    // threshold compare, registered to keep the comparator off the sequencer path
    always_comb
    begin
        limit = ovp_pkg::VOLT_W'(mant_ff) << EXPONENT_N; // [R2]
        nxt_fault = INPUT_LINE_VOLTAGE > limit; // [R1]
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (RESET)
            fault_ff <= 1'b0;
        else
            fault_ff <= nxt_fault;
    end

    // response sequencer; its only inputs are this channel's fault, action bits and delay timer done
    always_comb
    begin
        resp = ovp_pkg::resp_t'(action_ff[ovp_pkg::ACT_RESP_MSB:ovp_pkg::ACT_RESP_LSB]); // [R8]
        retry_cfg = action_ff[ovp_pkg::ACT_RETRY_MSB:ovp_pkg::ACT_RETRY_LSB];
        delay_code = action_ff[ovp_pkg::ACT_DELAY_MSB:ovp_pkg::ACT_DELAY_LSB];
        retry_left = (retry_cfg == ovp_pkg::RETRY_INFINITE) || (retries_ff != 3'h0); // [R9]
        nxt_state = state_ff;
        nxt_retries = retries_ff;
        nxt_enable = enable_ff;
        tif.start = 1'b0;
        tif.load_ms = ovp_pkg::DELAY2_MS[delay_code];
        case (state_ff)
            ovp_pkg::ST_RUN:
            begin
                nxt_enable = 1'b1;
                if (fault_ff)
                begin
                    case (resp)
                        ovp_pkg::RESP_IGNORE:
                            nxt_state = ovp_pkg::ST_RUN; // [R4]
                        ovp_pkg::RESP_RIDE:
                        begin
                            nxt_state = ovp_pkg::ST_RIDE; // [R5]
                            tif.start = 1'b1; // [R11]
                            tif.load_ms = ovp_pkg::DELAY1_MS[delay_code];
                        end
                        ovp_pkg::RESP_RETRY:
                        begin
                            nxt_state = ovp_pkg::ST_OFF; // [R6]
                            nxt_enable = 1'b0;
                            nxt_retries = retry_cfg; // [R9]
                            tif.start = 1'b1; // [R11]
                        end
                        ovp_pkg::RESP_HOLD:
                        begin
                            nxt_state = ovp_pkg::ST_HOLD; // [R7]
                            nxt_enable = 1'b0;
                        end
                        default:
                            nxt_state = ovp_pkg::ST_RUN;
                    endcase
                end
            end
            ovp_pkg::ST_RIDE:
            begin
                // output keeps running through the first delay
                if (!fault_ff)
                    nxt_state = ovp_pkg::ST_RUN;
                else if (tif.done)
                begin
                    nxt_state = ovp_pkg::ST_OFF; // [R5]
                    nxt_enable = 1'b0;
                    nxt_retries = retry_cfg;
                    tif.start = 1'b1; // [R11]
                end
            end
            ovp_pkg::ST_OFF:
            begin
                nxt_enable = 1'b0;
                if (tif.done && !tif.start)
                begin
                    if (retry_left)
                    begin
                        nxt_state = ovp_pkg::ST_TRY; // [R6]
                        nxt_enable = 1'b1;
                        if (retry_cfg != ovp_pkg::RETRY_INFINITE)
                            nxt_retries = retries_ff - 3'h1; // [R9]
                        tif.start = 1'b1; // [R11]
                    end
                    else if (fault_ff)
                        nxt_state = ovp_pkg::ST_LATCH; // [R10]
                    else
                    begin
                        nxt_state = ovp_pkg::ST_RUN;
                        nxt_enable = 1'b1;
                    end
                end
            end
            ovp_pkg::ST_TRY:
            begin
                // a retry counts as good once one spacing interval passes fault free
                if (fault_ff)
                begin
                    nxt_state = ovp_pkg::ST_OFF; // [R6]
                    nxt_enable = 1'b0;
                    tif.start = 1'b1; // [R11]
                end
                else if (tif.done)
                    nxt_state = ovp_pkg::ST_RUN;
            end
            ovp_pkg::ST_HOLD:
            begin
                nxt_enable = 1'b0;
                if (!fault_ff)
                begin
                    nxt_state = ovp_pkg::ST_RUN; // [R7]
                    nxt_enable = 1'b1;
                end
            end
            ovp_pkg::ST_LATCH:
                nxt_enable = 1'b0; // [R10]
            default:
            begin
                nxt_state = ovp_pkg::ST_LATCH;
                nxt_enable = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (RESET)
        begin
            state_ff <= ovp_pkg::ST_RUN;
            retries_ff <= 3'h0;
            enable_ff <= 1'b1;
        end
        else
        begin
            state_ff <= nxt_state;
            retries_ff <= nxt_retries;
            enable_ff <= nxt_enable;
        end
    end

    assign REG_RDATA = rdata_ff;
    assign REG_RVALID = rvalid_ff;
    assign OUTPUT_ENABLE = enable_ff;
    assign FAULT_ACTIVE = fault_ff;
    assign LATCHED_OFF = (state_ff == ovp_pkg::ST_LATCH);
endmodule // input_overvoltage_fault_handler

//--- testbench/ovp_checker_assertions.sv
// port-level assertions for the input overvoltage fault handler
`timescale 1ns/1ps
module ovp_checker
#(
    parameter int CYCLES_PER_MS = ovp_pkg::CYCLES_PER_MS
)
(
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire logic [7:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [15:0] REG_RDATA,
    input wire logic REG_RVALID,
    input wire logic [ovp_pkg::EXP_W-1:0] EXPONENT_N,
    input wire logic [ovp_pkg::VOLT_W-1:0] INPUT_LINE_VOLTAGE,
    input wire logic OUTPUT_ENABLE,
    input wire logic FAULT_ACTIVE,
    input wire logic LATCHED_OFF
);
    logic [10:0] mant_ff, nxt_mant;
    logic [7:0] act_ff, nxt_act;
    logic [ovp_pkg::VOLT_W-1:0] limit;

    // shadow copies of the two registers, so reads and compares can be predicted
    always_comb
    begin
        nxt_mant = mant_ff;
        nxt_act = act_ff;
        if (REG_WR && REG_ADDR == ovp_pkg::THRESHOLD_ADDR)
            nxt_mant = REG_WDATA[10:0];
        if (REG_WR && REG_ADDR == ovp_pkg::ACTION_ADDR)
            nxt_act = REG_WDATA[7:0];
        if (RESET)
        begin
            nxt_mant = ovp_pkg::THR_MANT_RESET;
            nxt_act = ovp_pkg::ACTION_RESET;
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        mant_ff <= nxt_mant;
        act_ff <= nxt_act;
    end

    assign limit = {7'h00, mant_ff} << EXPONENT_N;

    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RESET);

    fault_compare_a: assert property (!$past(RESET) |->
        FAULT_ACTIVE == ($past(INPUT_LINE_VOLTAGE) > $past(limit))) else $error("fault flag wrong");
    thr_read_a: assert property (REG_RD && REG_ADDR == ovp_pkg::THRESHOLD_ADDR |=>
        REG_RVALID && REG_RDATA == {2'b00, $past(EXPONENT_N), $past(mant_ff)}) else $error("threshold read wrong");
    act_read_a: assert property (REG_RD && REG_ADDR == ovp_pkg::ACTION_ADDR |=>
        REG_RDATA == {8'h00, $past(act_ff)}) else $error("action read wrong");
    shut_fast_a: assert property (act_ff[7] && OUTPUT_ENABLE && $rose(FAULT_ACTIVE) |=>
        !OUTPUT_ENABLE) else $error("output not cut at once");
    hold_restore_a: assert property (act_ff[7:6] == 2'h3 && !LATCHED_OFF && $fell(FAULT_ACTIVE) |=>
        OUTPUT_ENABLE) else $error("output not restored");
    latch_off_a: assert property (LATCHED_OFF |-> !OUTPUT_ENABLE) else $error("latched but enabled");
    latch_stays_a: assert property (LATCHED_OFF |=> LATCHED_OFF) else $error("latch left without reset");
    reset_values_a: assert property (disable iff (1'b0) RESET |=>
        OUTPUT_ENABLE && !FAULT_ACTIVE && !LATCHED_OFF && !REG_RVALID) else $error("reset state wrong");

    cover property (LATCHED_OFF);
    cover property (act_ff[7:6] == 2'h3 && $fell(FAULT_ACTIVE));
    cover property (act_ff[7:6] == 2'h1 && $fell(OUTPUT_ENABLE));
endmodule // ovp_checker

bind input_overvoltage_fault_handler ovp_checker #(.CYCLES_PER_MS(CYCLES_PER_MS)) chk (.CLK_SYS(CLK_SYS),
    .RESET(RESET), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .EXPONENT_N(EXPONENT_N),
    .INPUT_LINE_VOLTAGE(INPUT_LINE_VOLTAGE), .OUTPUT_ENABLE(OUTPUT_ENABLE), .FAULT_ACTIVE(FAULT_ACTIVE),
    .LATCHED_OFF(LATCHED_OFF));

//--- testbench/line_source.sv
// measured input line voltage source standing in for the boost stage sensing path
`timescale 1ns/1ps
module line_source
(
    input wire logic clk,
    input wire logic [1:0] mode,
    output logic [ovp_pkg::VOLT_W-1:0] volts
);
    // a measurement lands one clock after the commanded change, like a sampled reading
    initial volts = '0;
    always @(posedge clk)
        volts <= (mode == 2'h2) ? 18'h00401 : (mode == 2'h1) ? 18'h00400 : 18'h00123;
endmodule // line_source

//--- testbench/input_overvoltage_fault_handler_bench.sv
// self-checking bench for the input overvoltage fault handler
`timescale 1ns/1ps
module input_overvoltage_fault_handler_bench;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rvalid, oe, fault, latched;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000, rdata;
    logic [2:0] expn = 3'h2;
    logic [1:0] mode = 2'h0;
    logic [17:0] volts;
    int errors = 0, check_count = 0;

    input_overvoltage_fault_handler #(.CYCLES_PER_MS(4)) DUT (.CLK_SYS(clk), .RESET(rst), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .REG_RVALID(rvalid),
        .EXPONENT_N(expn), .INPUT_LINE_VOLTAGE(volts), .OUTPUT_ENABLE(oe), .FAULT_ACTIVE(fault),
        .LATCHED_OFF(latched));
    line_source src (.clk(clk), .mode(mode), .volts(volts));

    initial forever #50 clk = ~clk;

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic do_reset;
        mode = 2'h0;
        rst = 1'b1;
        tick(4);
        rst = 1'b0;
        chk({13'h0, fault, latched, oe}, 16'h0001);
    endtask

    // an edge passes after each strobe so back to back calls never re-raise it in one time step
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        tick(1);
        wr = 1'b0;
        tick(1);
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [15:0] exp);
        addr = a;
        rd = 1'b1;
        tick(1);
        rd = 1'b0;
        chk({15'h0, rvalid}, 16'h0001);
        chk(rdata, exp);
        tick(1);
        chk({15'h0, rvalid}, 16'h0000);
        chk(rdata, exp);
    endtask

    // threshold limit becomes 0x100 << 3 = 0x800 here, and 0x400 once s_ignore sets N back to 2
    task automatic s_regs;
        rd_reg(ovp_pkg::THRESHOLD_ADDR, 16'h17ff);
        rd_reg(ovp_pkg::ACTION_ADDR, 16'h0000);
        wr_reg(ovp_pkg::THRESHOLD_ADDR, 16'hf900);
        rd_reg(ovp_pkg::THRESHOLD_ADDR, 16'h1100);
        wr_reg(ovp_pkg::ACTION_ADDR, 16'hff3a);
        rd_reg(ovp_pkg::ACTION_ADDR, 16'h003a);
        rd_reg(8'h57, 16'h0000);
        expn = 3'h3;
        rd_reg(ovp_pkg::THRESHOLD_ADDR, 16'h1900);
        wr_reg(ovp_pkg::ACTION_ADDR, 16'h0000);
    endtask

    // exponent 3 lifts the limit to 0x800, so 0x401 is no fault until N drops back to 2
    task automatic s_ignore;
        mode = 2'h2;
        tick(3);
        chk({15'h0, fault}, 16'h0000);
        expn = 3'h2;
        tick(2);
        chk({15'h0, fault}, 16'h0001);
        mode = 2'h1;
        tick(3);
        chk({15'h0, fault}, 16'h0000);
        mode = 2'h2;
        tick(3);
        chk({15'h0, fault}, 16'h0001);
        tick(60);
        chk({15'h0, oe}, 16'h0001);
        mode = 2'h0;
        tick(3);
    endtask

    task automatic s_hold;
        wr_reg(ovp_pkg::ACTION_ADDR, 16'h00c0);
        mode = 2'h2;
        tick(3);
        chk({15'h0, oe}, 16'h0000);
        tick(30);
        chk({15'h0, oe}, 16'h0000);
        mode = 2'h0;
        tick(3);
        chk({15'h0, oe}, 16'h0001);
    endtask

    // shut down, retry n times with 1008-cycle spacing, then latch unless n is infinite
    task automatic s_retry(input logic [2:0] n);
        do_reset();
        wr_reg(ovp_pkg::THRESHOLD_ADDR, 16'h0100);
        wr_reg(ovp_pkg::ACTION_ADDR, {8'h00, 2'h2, n, 3'h0});
        mode = 2'h2;
        tick(3);
        chk({15'h0, oe}, 16'h0000);
        tick(1000 * (n == 3'h7 ? 4 : n + 1));
        chk({15'h0, latched}, 16'h0000);
        tick(40);
        chk({15'h0, latched}, {15'h0, n != 3'h7});
        mode = 2'h0;
        tick(10);
        chk({14'h0, latched, oe}, {14'h0, n != 3'h7, 1'b0});
        tick(1010);
        chk({14'h0, latched, oe}, {14'h0, n != 3'h7, n == 3'h7});
    endtask

    // ride-through with a fault that clears and returns, restarting the 80-cycle first delay
    task automatic s_ride;
        do_reset();
        wr_reg(ovp_pkg::THRESHOLD_ADDR, 16'h0100);
        wr_reg(ovp_pkg::ACTION_ADDR, 16'h0041);
        mode = 2'h2;
        tick(25);
        mode = 2'h0;
        tick(5);
        mode = 2'h2;
        tick(75);
        chk({15'h0, oe}, 16'h0001);
        tick(15);
        chk({15'h0, oe}, 16'h0000);
    endtask

    task automatic print_verdict;
        $display("errors=%0d checks=%0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        do_reset();
        s_regs();
        s_ignore();
        s_hold();
        s_retry(3'h0);
        s_retry(3'h1);
        s_retry(3'h7);
        s_ride();
        print_verdict();
    end

    // the whole run needs about 10500 cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        print_verdict();
    end
endmodule // input_overvoltage_fault_handler_bench
